/* File: src/irr_receiver.sv */
// Infrared remote-control receiver: APB registers, noise filter, prescalers,
// PPM and Manchester bit decoding, shift and data registers, event flags.
// Assumes ir_in and subclk_tick are synchronous to pclk.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

// Contract
// - Run bit 0 keeps receiver stopped; 1 starts it waiting for input.
// - Format field picks guide type, PPM or Manchester, stop bit, five codes; the code decodes no stop bit in any format.
// - Polarity bit 0 positive phase, 1 negative; levels read accordingly.
// - Input already active at start counts as a detected start edge.
// - Reference clock field selects 4..128 cycles, subclock, or one cycle.
// - In standby only subclock reference keeps running; otherwise receiver halts.
// - Guide flag set on valid guide in formats 0, 1, 4 only.
// - Four flags stay set until software clears them.
// - Any flag with its enable raises interrupt and standby release.
// - Data error flag set when received data checking fails.
// - Receive end flag set on the format's end condition.
// - Every eighth bit copies shift to data register and sets byte-full.
// - Shift register cleared on stop, guide, first edge, and transfer.
// - Three-bit counter counts decoded bits; leftover count at end.
// - Bit counter cleared on stop, valid guide, or first edge.
// - Low four bits of counter/prescale register are read-only.
// - Formats 0-2 prescale selects give 4, 8, 16, 32.
// - Formats 3-4 prescale selects give 2, 4, 8, 16.
// - End sets suspend; shift read or run clear resumes reception.
// - Formats 2 and 3 ignore the guide prescale select.
// - Direction bit 0 loads LSB first, 1 loads MSB first.
// - Input accepted only after four equal reference-clock samples.
// - Five-bit prescaler ticks pulse-width counter per division count.
module irr_receiver (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [irr_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ir_in,
	input wire logic subclk_tick,
	input wire logic xtal_standby,
	output logic irq,
	output logic standby_release
);
	import irr_pkg::*;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Last count of the pulse-width prescaler for a format and select
	function automatic logic [4:0] presc_max(input logic [2:0] fmt, input logic [1:0] sel);
		logic [5:0] cnt;
		cnt = ((fmt == FMT_D) || (fmt == FMT_E)) ? (MAN_BASE << sel) : (PPM_BASE << sel);
		return 5'(cnt - 6'h01);
	endfunction : presc_max

	// Width falls inside a half-open window
	function automatic logic in_win(input logic [4:0] w, input logic [4:0] lo,
		input logic [4:0] hi);
		return (w >= lo) && (w < hi);
	endfunction : in_win

	irr_state_s r, n;
	logic run, halted, ref_tick, ptick, act_old, act_new, rise, fall, edge_any;
	logic meas, bit_ok, bit_val, guide_set, err_set, full_set, end_set;
	logic acc, in_guide_mode;
	logic [2:0] fmt, cks;
	logic [7:0] sft_new;
	logic [15:0] idx;

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign irq = r.irq;
	assign standby_release = r.wake;
	assign idx = paddr[ADDR_W-1:2];

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------

	// All behaviour in one pass; APB effects applied after the decoder
	always_comb begin
		n = r;
		run = r.ctrl[CTRL_RUN];
		fmt = r.ctrl[6:4];
		cks = r.ctrl[2:0];
		halted = xtal_standby && (cks != REF_SUB);
		ref_tick = 1'b0;
		ptick = 1'b0;
		meas = 1'b0;
		bit_ok = 1'b0;
		bit_val = 1'b0;
		guide_set = 1'b0;
		err_set = 1'b0;
		full_set = 1'b0;
		end_set = 1'b0;
		sft_new = r.sft;
		act_old = r.filt ^ r.ctrl[CTRL_POL];
		act_new = act_old;
		rise = 1'b0;
		fall = 1'b0;
		edge_any = 1'b0;
		in_guide_mode = 1'b0;
		acc = psel && penable && r.pready;
		if (!run) begin
			// Stopping wipes the receive state; filter parks at the idle level
			n.st = ST_STOP;
			n.sft = RESET_BYTE;
			n.bcnt = 3'h0;
			n.div = 7'h00;
			n.presc = 5'h00;
			n.pwc = 5'h00;
			n.samp = {3{r.ctrl[CTRL_POL]}};
			n.filt = r.ctrl[CTRL_POL];
			n.half_pend = 1'b0;
		end else if (!halted) begin
			// Reference clock divider, counted in instruction cycles
			unique case (cks)
				REF_SUB: ref_tick = subclk_tick;
				REF_ONE: ref_tick = 1'b1;
				default: begin
					if (r.div == 7'((REF_BASE << cks) - 7'h01)) begin
						n.div = 7'h00;
						ref_tick = 1'b1;
					end else begin
						n.div = r.div + 7'h01;
					end
				end
			endcase
			// Four equal samples in a row before a level is believed
			if (ref_tick) begin
				n.samp = {r.samp[1:0], ir_in};
				if ((r.samp == {3{ir_in}}) && (ir_in != r.filt)) begin
					n.filt = ir_in;
				end
			end
			act_new = n.filt ^ r.ctrl[CTRL_POL];
			rise = act_new && !act_old;
			fall = !act_new && act_old;
			edge_any = rise || fall;
			// Guide prescale applies only while hunting a guide pulse
			in_guide_mode = ((r.st == ST_IDLE) || (r.st == ST_GUIDE))
				&& (fmt != FMT_C) && (fmt != FMT_D);
			if (ref_tick) begin
				if (r.presc >= presc_max(fmt, in_guide_mode ? r.gpr : r.dpr)) begin
					n.presc = 5'h00;
					ptick = 1'b1;
				end else begin
					n.presc = r.presc + 5'h01;
				end
			end
			if (ptick && (r.pwc != PWC_MAX)) begin
				n.pwc = r.pwc + 5'h01;
			end
			unique case (r.st)
				ST_STOP: begin
					n.st = ST_IDLE;
					n.pwc = 5'h00;
				end
				ST_IDLE: begin
					if (rise) begin
						n.pwc = 5'h00;
						n.presc = 5'h00;
						if ((fmt == FMT_C) || (fmt == FMT_D)) begin
							// No guide: the first edge opens the frame
							n.sft = RESET_BYTE;
							n.bcnt = 3'h0;
							n.half_pend = 1'b0;
							n.st = ST_DATA;
						end else begin
							n.st = ST_GUIDE;
						end
					end
				end
				ST_GUIDE: begin
					// Half-clock guide ends on the fall, clock guides on next rise
					meas = (fmt == FMT_A) ? fall : rise;
					if (meas) begin
						n.pwc = 5'h00;
						n.presc = 5'h00;
						if (in_win(r.pwc, GUIDE_LO, GUIDE_HI)) begin
							guide_set = 1'b1;
							n.sft = RESET_BYTE;
							n.bcnt = 3'h0;
							n.half_pend = 1'b0;
							n.st = ST_DATA;
						end else begin
							n.st = rise ? ST_GUIDE : ST_IDLE;
						end
					end else if (r.pwc >= GUIDE_HI) begin
						n.st = ST_IDLE;
					end
				end
				ST_DATA: begin
					if ((fmt == FMT_D) || (fmt == FMT_E)) begin
						meas = edge_any;
					end else begin
						meas = (fmt == FMT_A) ? fall : rise;
					end
					if (meas) begin
						n.pwc = 5'h00;
						n.presc = 5'h00;
						if ((fmt == FMT_D) || (fmt == FMT_E)) begin
							// Manchester: a full interval or two halves give one bit
							if (in_win(r.pwc, D1_LO, D1_HI)) begin
								bit_ok = !r.half_pend;
								err_set = r.half_pend;
							end else if (in_win(r.pwc, D0_LO, D0_HI)) begin
								bit_ok = r.half_pend;
								n.half_pend = !r.half_pend;
							end else begin
								err_set = 1'b1;
							end
							bit_val = act_new;
						end else if (in_win(r.pwc, D0_LO, D0_HI)) begin
							bit_ok = 1'b1;
							bit_val = 1'b0;
						end else if (in_win(r.pwc, D1_LO, D1_HI)) begin
							bit_ok = 1'b1;
							bit_val = 1'b1;
						end else begin
							err_set = 1'b1;
						end
						if (err_set) begin
							n.st = ST_IDLE;
						end
					end else if (r.pwc >= END_W) begin
						end_set = 1'b1;
						n.st = ST_HOLD;
					end
					if (bit_ok) begin
						sft_new = r.dir ? {r.sft[6:0], bit_val} : {bit_val, r.sft[7:1]};
						n.bcnt = r.bcnt + 3'h1;
						if (r.bcnt == 3'h7) begin
							n.rdt = sft_new;
							n.sft = RESET_BYTE;
							full_set = 1'b1;
						end else begin
							n.sft = sft_new;
						end
					end
				end
				ST_HOLD: begin
					n.pwc = 5'h00; // Input ignored while suspended
				end
			endcase
		end
		// APB write and read side effects at the completing edge
		if (acc && pwrite && (paddr[1:0] == 2'b00)) begin
			unique case (idx)
				IDX_CTRL: n.ctrl = pwdata[7:0];
				IDX_INTC: begin
					// Flags can only be cleared by software
					n.intc = (pwdata[7:0] & INTC_ENS) | (r.intc & pwdata[7:0] & INTC_FLAGS);
				end
				IDX_CTPR: begin
					n.gpr = pwdata[7:6];
					n.dpr = pwdata[5:4];
				end
				IDX_DIR: n.dir = pwdata[DIR_BIT];
				default: n.ctrl = n.ctrl;
			endcase
		end
		if (acc && !pwrite && (idx == IDX_SHIFT) && (paddr[1:0] == 2'b00)
			&& (n.st == ST_HOLD)) begin
			n.st = ST_IDLE;
		end
		// Hardware sets win over a simultaneous software clear
		n.intc[F_GUIDE] = n.intc[F_GUIDE] | guide_set;
		n.intc[F_ERR] = n.intc[F_ERR] | err_set;
		n.intc[F_FULL] = n.intc[F_FULL] | full_set;
		n.intc[F_END] = n.intc[F_END] | end_set;
		n.irq = |(n.intc & INTC_FLAGS & {n.intc[6:0], 1'b0});
		n.wake = n.irq;
		// Registered answer: one wait cycle in every access phase
		n.pready = psel && penable && !r.pready;
		n.pslverr = 1'b0;
		n.prdata = 32'h0000_0000;
		if (n.pready) begin
			unique case (paddr[1:0] == 2'b00 ? idx : 16'h0000)
				IDX_CTRL: n.prdata[7:0] = r.ctrl;
				IDX_INTC: n.prdata[7:0] = r.intc;
				IDX_SHIFT: n.prdata[7:0] = r.sft;
				IDX_DATA: n.prdata[7:0] = r.rdt;
				IDX_CTPR: n.prdata[7:0] = {r.gpr, r.dpr, r.st == ST_HOLD, r.bcnt};
				IDX_DIR: n.prdata[DIR_BIT] = r.dir;
				default: n.pslverr = 1'b1;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	// Single register of the whole state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{default: '0, st: ST_STOP};
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_stop_clears;
		!r.ctrl[CTRL_RUN] |=> (r.st == ST_STOP) && (r.sft == 8'h00) && (r.bcnt == 3'h0);
	endproperty
	a_stop_clears: assert property (p_stop_clears) else $error("Stop did not clear");

	property p_guide_formats;
		$rose(r.intc[F_GUIDE]) |-> (r.ctrl[6:4] == FMT_A) || (r.ctrl[6:4] == FMT_B)
			|| (r.ctrl[6:4] == FMT_E);
	endproperty
	a_guide_formats: assert property (p_guide_formats) else $error("Guide flag bad format");

	property p_irq_or;
		irq == |(r.intc & INTC_FLAGS & {r.intc[6:0], 1'b0}) && standby_release == irq;
	endproperty
	a_irq_or: assert property (p_irq_or) else $error("Interrupt mismatch");

	property p_full_transfer;
		$rose(r.intc[F_FULL]) |-> (r.sft == 8'h00) && (r.bcnt == 3'h0) && $changed(r.bcnt);
	endproperty
	a_full_transfer: assert property (p_full_transfer) else $error("Byte full mismatch");

	property p_bcnt_step;
		$changed(r.bcnt) |-> (r.bcnt == 3'($past(r.bcnt) + 3'h1)) || (r.bcnt == 3'h0);
	endproperty
	a_bcnt_step: assert property (p_bcnt_step) else $error("Bit counter jumped");

	property p_end_holds;
		$rose(r.intc[F_END]) |-> (r.st == ST_HOLD);
	endproperty
	a_end_holds: assert property (p_end_holds) else $error("End without suspend");

	property p_hold_frozen;
		(r.st == ST_HOLD && r.ctrl[CTRL_RUN]) ##1 r.ctrl[CTRL_RUN] |-> $stable(r.sft);
	endproperty
	a_hold_frozen: assert property (p_hold_frozen) else $error("Shift moved in suspend");

	property p_filter;
		$changed(r.filt) && $past(r.ctrl[CTRL_RUN]) && r.ctrl[CTRL_RUN] |-> r.samp == {3{r.filt}};
	endproperty
	a_filter: assert property (p_filter) else $error("Filter took short pulse");

	property p_presc_limit;
		r.presc <= 5'h1F && (r.ctrl[6:4] == FMT_D || r.ctrl[6:4] == FMT_E) |-> r.presc <= 5'h0F;
	endproperty
	a_presc_limit: assert property (p_presc_limit) else $error("Prescaler overran");

	property p_standby_halt;
		xtal_standby && r.ctrl[CTRL_RUN] && r.ctrl[2:0] != REF_SUB
			|=> $stable(r.presc) && $stable(r.filt) && $stable(r.div);
	endproperty
	a_standby_halt: assert property (p_standby_halt) else $error("Ran in standby");

	c_guide: cover property ($rose(r.intc[F_GUIDE]));
	c_full: cover property ($rose(r.intc[F_FULL]));
	c_error: cover property ($rose(r.intc[F_ERR]));
	c_resume: cover property (r.st == ST_HOLD ##1 r.st == ST_IDLE);

endmodule : irr_receiver

/* File: src/irr_pkg.sv */
// Constants, types and register map of the infrared remote-control receiver.
// Assumes a 50 MHz pclk that also serves as the instruction cycle clock.
package irr_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 18;
	localparam logic [15:0] IDX_CTRL = 16'hFEC7;
	localparam logic [15:0] IDX_INTC = 16'hFEC8;
	localparam logic [15:0] IDX_SHIFT = 16'hFEC9;
	localparam logic [15:0] IDX_DATA = 16'hFECA;
	localparam logic [15:0] IDX_CTPR = 16'hFECB;
	localparam logic [15:0] IDX_DIR = 16'hFECF;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_RUN = 7;
	localparam int CTRL_POL = 3;
	localparam int DIR_BIT = 7;
	localparam int HOLD_BIT = 3;
	localparam int F_GUIDE = 7;
	localparam int F_ERR = 5;
	localparam int F_FULL = 3;
	localparam int F_END = 1;
	localparam logic [7:0] INTC_FLAGS = 8'hAA;
	localparam logic [7:0] INTC_ENS = 8'h55;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// ----------------------------------------------------------------
	// Format and reference clock codes
	// ----------------------------------------------------------------
	localparam logic [2:0] FMT_A = 3'h0;
	localparam logic [2:0] FMT_B = 3'h1;
	localparam logic [2:0] FMT_C = 3'h2;
	localparam logic [2:0] FMT_D = 3'h3;
	localparam logic [2:0] FMT_E = 3'h4;
	localparam logic [2:0] REF_SUB = 3'h6;
	localparam logic [2:0] REF_ONE = 3'h7;
	localparam logic [6:0] REF_BASE = 7'h04;
	localparam logic [5:0] PPM_BASE = 6'h04;
	localparam logic [5:0] MAN_BASE = 6'h02;

	// ----------------------------------------------------------------
	// Fixed pulse criteria, in pulse-width counter ticks (lo <= w < hi)
	// ----------------------------------------------------------------
	localparam logic [4:0] GUIDE_LO = 5'h08;
	localparam logic [4:0] GUIDE_HI = 5'h18;
	localparam logic [4:0] D0_LO = 5'h02;
	localparam logic [4:0] D0_HI = 5'h06;
	localparam logic [4:0] D1_LO = 5'h06;
	localparam logic [4:0] D1_HI = 5'h0C;
	localparam logic [4:0] END_W = 5'h0D;
	localparam logic [4:0] PWC_MAX = 5'h1F;

	typedef enum logic [2:0] {ST_STOP, ST_IDLE, ST_GUIDE, ST_DATA, ST_HOLD} irr_state_e;

	// Whole state of the receiver
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] intc;
		logic [7:0] sft;
		logic [7:0] rdt;
		logic [1:0] gpr;
		logic [1:0] dpr;
		logic dir;
		logic [2:0] bcnt;
		irr_state_e st;
		logic [6:0] div;
		logic [4:0] presc;
		logic [4:0] pwc;
		logic [2:0] samp;
		logic filt;
		logic half_pend;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic irq;
		logic wake;
	} irr_state_s;

endpackage : irr_pkg

/* File: test/irr_ir_source.sv */
// Behavioural infrared front end: turns interval lists into demodulated pulses.
// Assumes the receiver samples ir_out on pclk; intervals are in pclk cycles.
`timescale 1ns/1ps
module irr_ir_source (
	input wire logic pclk,
	input wire logic polarity,
	output logic ir_out
);
	logic act = 1'b0;

	// Idle is always the inactive level of the chosen phase
	assign ir_out = act ^ polarity;

	// One rise, then the next rise lands gap cycles later; short active part
	// keeps the tail free of extra edges
	task automatic pulse(input int gap);
		int hi;
		hi = (gap >= 24) ? 12 : gap / 2;
		@(posedge pclk);
		act <= 1'b1;
		repeat (hi) @(posedge pclk);
		act <= 1'b0;
		repeat (gap - hi - 1) @(posedge pclk);
	endtask : pulse

	// Optional lead interval, one interval per bit, then a long quiet tail
	task automatic frame(input logic [15:0] v, input int n, input int lead, input int w0,
		input int w1);
		int i;
		if (lead > 0) begin
			pulse(lead);
		end
		for (i = 0; i < n; i++) begin
			pulse(v[i] ? w1 : w0);
		end
		pulse(160);
	endtask : frame
endmodule : irr_ir_source

/* File: test/tb_top.sv */
// Self-checking bench of the infrared receiver: APB register access and frames.
// Assumes irr_pkg and the behavioural source model are compiled first.
`timescale 1ns/1ps
module tb_top;
	import irr_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic psel, penable, pwrite, subclk_tick, xtal_standby, pol, ir_in, pready, pslverr;
	logic irq, standby_release;
	logic [31:0] prdata;
	logic [7:0] exp_s, exp_r, rd, c;
	logic e;
	int err_count = 0;
	int checks = 0;
	logic [15:0] regs [6] = '{IDX_CTRL, IDX_INTC, IDX_SHIFT, IDX_DATA, IDX_CTPR, IDX_DIR};

	// ----------------------------------------------------------------
	// Clock, design and far-side model
	// ----------------------------------------------------------------
	always #10 pclk = ~pclk;
	// Subclock enable every other cycle, fast enough for short runs
	always @(posedge pclk) subclk_tick <= !subclk_tick;

	irr_receiver dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ir_in(ir_in), .subclk_tick(subclk_tick),
		.xtal_standby(xtal_standby), .irq(irq), .standby_release(standby_release));
	irr_ir_source src_u (.pclk(pclk), .polarity(pol), .ir_out(ir_in));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// Setup, then access held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			tally_and_finish();
		end
		rd = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask : wr

	task automatic rchk(input logic [15:0] idx, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
		apb(1'b0, idx, 8'h00);
		check(rd & m, exp);
	endtask : rchk

	task automatic chk_irq(input logic x);
		check({6'h00, standby_release, irq}, {6'h00, x, x});
	endtask : chk_irq

	// Expected shift and data contents after n bits in the given direction
	task automatic model(input logic [15:0] v, input int n, input logic d);
		exp_s = 8'h00;
		exp_r = 8'h00;
		for (int i = 0; i < n; i++) begin
			exp_s = d ? {exp_s[6:0], v[i]} : {v[i], exp_s[7:1]};
			if (i % 8 == 7) begin
				exp_r = exp_s;
				exp_s = 8'h00;
			end
		end
	endtask : model

	// Configuration is written with reception stopped
	task automatic cfg(input logic [7:0] cr, input logic [7:0] cp, input logic [7:0] ic,
		input logic [7:0] dr);
		wr(IDX_CTRL, cr);
		wr(IDX_CTPR, cp);
		wr(IDX_INTC, ic);
		wr(IDX_DIR, dr);
	endtask : cfg

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, subclk_tick, xtal_standby, pol} = 6'h00;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		foreach (regs[i]) rchk(regs[i], 8'h00);
		apb(1'b0, 16'hFEC6, 8'h00);
		check({7'h00, e}, 8'h01);
		wr(IDX_SHIFT, 8'hFF);
		rchk(IDX_SHIFT, 8'h00);
		wr(IDX_CTPR, 8'hFF);
		rchk(IDX_CTPR, 8'hF0);
		wr(IDX_DIR, 8'hFF);
		rchk(IDX_DIR, 8'h80);
		// Only the five legal format codes are ever written
		for (int f = 0; f < 5; f++) begin
			for (int r = 0; r < 8; r++) begin
				c = {1'b0, f[2:0], 1'b0, r[2:0]};
				wr(IDX_CTRL, c);
				rchk(IDX_CTRL, c);
			end
		end
		// Clock-guide PPM frame of 11 bits, LSB first
		model(16'h05A3, 11, 1'b0);
		cfg(8'h17, 8'h00, 8'h01, 8'h00);
		src_u.frame(16'h05A3, 11, 48, 16, 32);
		rchk(IDX_INTC, 8'h01);
		wr(IDX_CTRL, 8'h97);
		src_u.frame(16'h05A3, 11, 48, 16, 32);
		rchk(IDX_INTC, 8'h8B);
		chk_irq(1'b1);
		rchk(IDX_CTPR, 8'h0B);
		rchk(IDX_DATA, exp_r);
		src_u.frame(16'h00FF, 8, 48, 16, 32);
		rchk(IDX_DATA, exp_r);
		wr(IDX_INTC, 8'h01);
		rchk(IDX_INTC, 8'h01);
		chk_irq(1'b0);
		rchk(IDX_SHIFT, exp_s);
		rchk(IDX_CTPR, 8'h00, 8'h08);
		wr(IDX_CTRL, 8'h17);
		rchk(IDX_CTPR, 8'h00);
		rchk(IDX_SHIFT, 8'h00);
		// Slow data prescale turns a short interval into a data error
		cfg(8'h17, 8'h30, 8'h10, 8'h00);
		wr(IDX_CTRL, 8'h97);
		src_u.pulse(48);
		src_u.pulse(16);
		src_u.pulse(160);
		rchk(IDX_INTC, 8'hB0, 8'hF0);
		chk_irq(1'b1);
		// No-guide format, negative phase, MSB first, odd guide prescale
		wr(IDX_CTRL, 8'h17);
		pol <= 1'b1;
		model(16'h00C5, 8, 1'b1);
		cfg(8'h2F, 8'hC0, 8'h00, 8'h80);
		wr(IDX_CTRL, 8'hAF);
		src_u.frame(16'h00C5, 8, 0, 16, 32);
		rchk(IDX_INTC, 8'h0A);
		rchk(IDX_DATA, exp_r);
		rchk(IDX_CTPR, 8'hC8);
		rchk(IDX_SHIFT, 8'h00);
		wr(IDX_CTRL, 8'h2F);
		pol <= 1'b0;
		// Manchester without and with guide: three half-interval pairs, then a stray half
		for (int f = 3; f < 5; f++) begin
			cfg({1'b0, f[2:0], 4'h7}, 8'h00, 8'h00, 8'h00);
			wr(IDX_CTRL, {1'b1, f[2:0], 4'h7});
			src_u.frame(16'h0000, 3, (f == 4) ? 32 : 0, 16, 16);
			rchk(IDX_INTC, (f == 4) ? 8'h82 : 8'h02);
			rchk(IDX_CTPR, 8'h0B);
			rchk(IDX_SHIFT, 8'hE0);
			wr(IDX_CTRL, {1'b0, f[2:0], 4'h7});
		end
		// Standby halts a cycle-clocked receiver but not a subclocked one
		cfg(8'h17, 8'h00, 8'h00, 8'h00);
		xtal_standby <= 1'b1;
		wr(IDX_CTRL, 8'h97);
		src_u.frame(16'h00FF, 8, 48, 16, 32);
		rchk(IDX_INTC, 8'h00);
		wr(IDX_CTRL, 8'h16);
		wr(IDX_CTRL, 8'h96);
		src_u.frame(16'h00FF, 8, 96, 32, 64);
		rchk(IDX_INTC, 8'h8A);
		xtal_standby <= 1'b0;
		wr(IDX_CTRL, 8'h16);
		tally_and_finish();
	end

	// Overall limit against a hang anywhere above
	initial begin
		repeat (90000) @(posedge pclk);
		err_count++;
		tally_and_finish();
	end
endmodule : tb_top
